/* rtl/timer16_consts.vh */
/*
 * Register offsets, field positions, reset values and prescale counts of the
 * 16-bit timer/counter. Definitions only; included by the timer module.
 */
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH

// byte offsets on the register bus
`define CONTROL_WORD_OFFSET 8'h00
`define COUNT_VALUE_OFFSET 8'h04
`define PERIOD_OFFSET 8'h08
`define STATUS_OFFSET 8'h0C
`define MASK_OFFSET 8'h10
`define SOURCE_OFFSET 8'h14

// control word fields
`define RUN_ENABLE_BIT 15
`define IDLE_STOP_SELECT_BIT 13
`define GATE_ACCUMULATE_ENABLE_BIT 6
`define PRESCALE_HI_BIT 5
`define PRESCALE_LO_BIT 4
`define EXTERNAL_CLOCK_SYNC_SELECT_BIT 2
`define CLOCK_SOURCE_SELECT_BIT 1
`define CONTROL_WORD_WRITE_MASK 16'hA076

// source register field
`define OSC_SELECT_BIT 0

// status and mask fields
`define PERIOD_MATCH_BIT 0
`define GATE_END_BIT 1
`define EVENT_COUNT 2

// reset values
`define CONTROL_WORD_RESET 16'h0000
`define COUNT_VALUE_RESET 16'h0000
`define PERIOD_RESET 16'hFFFF
`define STATUS_RESET 2'h0
`define MASK_RESET 2'h0

// prescale select codes and the last count of each division
`define PRESCALE_DIV1 2'h0
`define PRESCALE_DIV8 2'h1
`define PRESCALE_DIV64 2'h2
`define PRESCALE_DIV256 2'h3
`define DIV1_LAST 8'h00
`define DIV8_LAST 8'h07
`define DIV64_LAST 8'h3F
`define DIV256_LAST 8'hFF

`endif

/* rtl/rtc_capable_timer16.v */
/*
 * 16-bit timer/counter usable as a real-time clock time base or as an
 * interval timer, with an APB register slave and one level interrupt.
 * Assumes pclk is the instruction cycle clock, idle_mode comes from logic
 * on pclk, and both count pins are asynchronous to pclk.
 */
`timescale 1ns/1ps
`include "timer16_consts.vh"

module rtc_capable_timer16 #(
    parameter ADDR_WIDTH = 8
) (
    input wire pclk,
    input wire presetn,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire external_count_input,
    input wire low_power_osc_clock,
    input wire idle_mode,
    output wire irq
);

    localparam [3:0] MODE_TIMER = 4'h1;
    localparam [3:0] MODE_GATED = 4'h2;
    localparam [3:0] MODE_SYNC_COUNTER = 4'h4;
    localparam [3:0] MODE_ASYNC_COUNTER = 4'h8;

    reg [15:0] control_word;
    reg [15:0] count_value;
    reg [15:0] period;
    reg [`EVENT_COUNT-1:0] status;
    reg [`EVENT_COUNT-1:0] mask;
    reg osc_select;
    reg [`EVENT_COUNT-1:0] read_clear;

    reg [1:0] pin_meta;
    reg [1:0] pin_sync;
    reg [1:0] pin_prev;
    reg [7:0] prescale_count;
    reg sync_stage;

    reg [3:0] mode;
    reg raw_tick;
    reg [7:0] prescale_last;
    reg [31:0] read_value;
    reg read_hit;
    reg [`EVENT_COUNT-1:0] next_status;

    wire run_enable;
    wire idle_stop_select;
    wire gate_accumulate_enable;
    wire [1:0] input_prescale_select;
    wire external_clock_sync_select;
    wire clock_source_select;
    wire [1:0] pin_rise;
    wire gate_fall;
    wire selected_rise;
    wire active;
    wire prescale_pulse;
    wire count_tick;
    wire period_match;
    wire gate_end;
    wire setup_phase;
    wire access_phase;
    wire bus_write;
    wire sync_counter_running;
    wire sync_mode;
    wire hit_control;
    wire hit_count;
    wire hit_period;
    wire hit_status;
    wire hit_mask;
    wire hit_source;
    wire count_write;
    wire status_read;
    wire [`EVENT_COUNT-1:0] new_events;

    assign run_enable = control_word[`RUN_ENABLE_BIT];
    assign idle_stop_select = control_word[`IDLE_STOP_SELECT_BIT];
    assign gate_accumulate_enable = control_word[`GATE_ACCUMULATE_ENABLE_BIT];
    assign input_prescale_select = control_word[`PRESCALE_HI_BIT:`PRESCALE_LO_BIT];
    assign external_clock_sync_select = control_word[`EXTERNAL_CLOCK_SYNC_SELECT_BIT];
    assign clock_source_select = control_word[`CLOCK_SOURCE_SELECT_BIT];

    // both pins are asynchronous: two flops before anything looks at them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            pin_prev <= 2'h0;
        end else begin
            pin_meta <= {low_power_osc_clock, external_count_input};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_rise = pin_sync & ~pin_prev;
    assign gate_fall = pin_prev[0] & ~pin_sync[0];
    // the oscillator input stands in for the pin as count source when selected; the gate always uses the pin
    assign selected_rise = osc_select ? pin_rise[1] : pin_rise[0];

    // source 0 ignores sync, source 1 ignores gate
    always @* begin
        if (!clock_source_select) begin
            if (gate_accumulate_enable) begin
                mode = MODE_GATED;
            end else begin
                mode = MODE_TIMER;
            end
        end else begin
            if (external_clock_sync_select) begin
                mode = MODE_SYNC_COUNTER;
            end else begin
                mode = MODE_ASYNC_COUNTER;
            end
        end
    end

    always @* begin
        case (mode)
            MODE_TIMER: begin
                raw_tick = 1'b1;
            end
            MODE_GATED: begin
                raw_tick = pin_sync[0];
            end
            MODE_SYNC_COUNTER: begin
                raw_tick = selected_rise;
            end
            MODE_ASYNC_COUNTER: begin
                raw_tick = selected_rise;
            end
            default: begin
                raw_tick = 1'b0;
            end
        endcase
    end

    always @* begin
        case (input_prescale_select)
            `PRESCALE_DIV1: begin
                prescale_last = `DIV1_LAST;
            end
            `PRESCALE_DIV8: begin
                prescale_last = `DIV8_LAST;
            end
            `PRESCALE_DIV64: begin
                prescale_last = `DIV64_LAST;
            end
            `PRESCALE_DIV256: begin
                prescale_last = `DIV256_LAST;
            end
            default: begin
                prescale_last = `DIV1_LAST;
            end
        endcase
    end

    assign active = run_enable & ~(idle_stop_select & idle_mode);

    // prescaler restarts from zero whenever the timer is halted
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_count <= 8'h00;
        end else if (!active) begin
            prescale_count <= 8'h00;
        end else if (raw_tick) begin
            if (prescale_count >= prescale_last) begin
                prescale_count <= 8'h00;
            end else begin
                prescale_count <= prescale_count + 8'h01;
            end
        end
    end

    assign prescale_pulse = active & raw_tick & (prescale_count >= prescale_last);

    // extra stage on the prescaled clock in synchronous counter mode only;
    // the asynchronous mode takes the prescaler output straight, trading
    // alignment to the bus view of the count for one cycle less latency
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_stage <= 1'b0;
        end else begin
            sync_stage <= prescale_pulse & sync_mode;
        end
    end

    assign sync_mode = (mode == MODE_SYNC_COUNTER);
    assign count_tick = sync_mode ?
        (sync_stage & active) :
        (prescale_pulse & ~sync_mode);
    assign period_match = count_tick & (count_value == period);
    // the gate flag marks the end of one accumulation so software can take the total
    assign gate_end = active & (mode == MODE_GATED) & gate_fall;
    assign new_events[`PERIOD_MATCH_BIT] = period_match;
    assign new_events[`GATE_END_BIT] = gate_end;

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign bus_write = access_phase & pwrite;
    assign sync_counter_running = run_enable & sync_mode;
    assign pready = 1'b1;

    // one decode per register, shared by the write, lockout and read-clear paths
    assign hit_control = (paddr == `CONTROL_WORD_OFFSET);
    assign hit_count = (paddr == `COUNT_VALUE_OFFSET);
    assign hit_period = (paddr == `PERIOD_OFFSET);
    assign hit_status = (paddr == `STATUS_OFFSET);
    assign hit_mask = (paddr == `MASK_OFFSET);
    assign hit_source = (paddr == `SOURCE_OFFSET);
    // a count write in the locked mode is dropped without an error
    assign count_write = bus_write & hit_count & ~sync_counter_running;
    assign status_read = access_phase & ~pwrite & hit_status;

    // counter: a software write loses to nothing but the sync-mode lockout
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= `COUNT_VALUE_RESET;
        end else if (count_write) begin
            count_value <= pwdata[15:0];
        end else if (period_match) begin
            count_value <= 16'h0000;
        end else if (count_tick) begin
            count_value <= count_value + 16'h0001;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_word <= `CONTROL_WORD_RESET;
            period <= `PERIOD_RESET;
            mask <= `MASK_RESET;
            osc_select <= 1'b0;
        end else if (bus_write) begin
            if (hit_control) begin
                control_word <= pwdata[15:0] & `CONTROL_WORD_WRITE_MASK;
            end
            if (hit_period) begin
                period <= pwdata[15:0];
            end
            if (hit_mask) begin
                mask <= pwdata[`EVENT_COUNT-1:0];
            end
            if (hit_source) begin
                osc_select <= pwdata[`OSC_SELECT_BIT];
            end
        end
    end

    // a read clears only the bits it returned, and a new event still sets
    always @* begin
        next_status = status;
        if (status_read) begin
            next_status = next_status & ~read_clear;
        end
        next_status = next_status | new_events;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= `STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    assign irq = |(status & mask);

    always @* begin
        read_value = 32'h0000_0000;
        read_hit = 1'b1;
        case (paddr)
            `CONTROL_WORD_OFFSET: begin
                read_value[15:0] = control_word;
            end
            `COUNT_VALUE_OFFSET: begin
                read_value[15:0] = count_value;
            end
            `PERIOD_OFFSET: begin
                read_value[15:0] = period;
            end
            `STATUS_OFFSET: begin
                read_value[`EVENT_COUNT-1:0] = status;
            end
            `MASK_OFFSET: begin
                read_value[`EVENT_COUNT-1:0] = mask;
            end
            `SOURCE_OFFSET: begin
                read_value[`OSC_SELECT_BIT] = osc_select;
            end
            default: begin
                read_hit = 1'b0;
            end
        endcase
    end

    // read data and the read-clear set are caught in the setup cycle so the
    // access cycle can answer at once from flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            read_clear <= `STATUS_RESET;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h0000_0000 : read_value;
            read_clear <= hit_status ? status : `STATUS_RESET;
        end
    end

    // the error stands through the access cycle only; it drops with the
    // edge that completes the transfer, since pready is always high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= ~read_hit;
        end else begin
            pslverr <= 1'b0;
        end
    end

endmodule // rtc_capable_timer16

/* sim/pulse_source.sv */
/*
 * Pulse source standing in for the external count pin or the slow oscillator.
 * Assumes it runs off pclk and is switched on by the bench for whole bursts.
 */
`timescale 1ns/1ps
module pulse_source #(
    parameter HALF = 4
) (
    input wire pclk,
    input wire run,
    output reg pin
);
    integer cnt = 0;
    // stands low between bursts, so no stray edge reaches the counter
    initial pin = 1'b0;
    always @(posedge pclk) begin
        if (!run) begin
            pin <= 1'b0;
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            pin <= ~pin;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // pulse_source

/* sim/rtc_capable_timer16_assertions.sv */
/*
 * Concurrent checks on the timer's bus and interrupt ports.
 * Assumes one clock pclk and the asynchronous active-low presetn.
 */
`timescale 1ns/1ps
`include "timer16_consts.vh"
module rtc_capable_timer16_assertions #(
    parameter ADDR_WIDTH = 8
) (
    input wire pclk,
    input wire presetn,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire bad = paddr > `SOURCE_OFFSET || paddr[1:0] != 2'h0;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    a_err_unmapped: assert property (s_setup ##1 s_access ##0 bad |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (s_access ##0 !bad |-> !pslverr)
        else $error("mapped access refused");
    a_read_stands: assert property (s_setup ##1 s_access |=> $stable(prdata))
        else $error("read data moved");
    a_bad_zero: assert property (s_access ##0 bad && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (s_access ##0 !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read bits set");
    a_write_rdata: assert property (s_access ##0 pwrite |-> prdata == 32'h0)
        else $error("read data during write");
    a_mask_quiet: assert property (s_access ##0 pwrite && paddr == `MASK_OFFSET
        && pwdata[1:0] == 2'h0 |=> !irq)
        else $error("irq with all events masked");
endmodule // rtc_capable_timer16_assertions

/* sim/rtc_capable_timer16_tb.sv */
/*
 * Self-checking bench: APB tasks and two pulse sources drive the timer.
 * Assumes the design answers with zero wait states.
 */
`timescale 1ns/1ps
`include "timer16_consts.vh"
module rtc_capable_timer16_tb;
    logic pclk, presetn, psel, penable, pwrite, ext_run, osc_run, idle_mode;
    logic [7:0] paddr;
    logic [31:0] pwdata, q;
    wire [31:0] prdata;
    wire pready, pslverr, irq, ext_pin, osc_pin;
    integer n_errors = 0, cmp_count = 0, cycles = 0, k, n;
    rtc_capable_timer16 dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_count_input(ext_pin),
        .low_power_osc_clock(osc_pin), .idle_mode(idle_mode), .irq(irq));
    // sources run scaled: a true 32 kHz rate would make the run far too long
    pulse_source #(.HALF(4)) ext (.pclk(pclk), .run(ext_run), .pin(ext_pin));
    pulse_source #(.HALF(4)) osc (.pclk(pclk), .run(osc_run), .pin(osc_pin));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task give_verdict;
        if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict;
        end
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(q, e);
    endtask
    // counts over w+3 enabled edges, then stops and reads the count
    task run(input logic [15:0] c, input integer w, input logic [31:0] e);
        apb(1'b1, `COUNT_VALUE_OFFSET, 32'h0);
        apb(1'b1, `CONTROL_WORD_OFFSET, {16'h0, c});
        repeat (w) @(posedge pclk);
        apb(1'b1, `CONTROL_WORD_OFFSET, 32'h0);
        rd(`COUNT_VALUE_OFFSET, e);
    endtask
    // leaves the counter running after b source edges have settled
    task burst(input logic o, input logic [15:0] c, input integer b);
        apb(1'b1, `CONTROL_WORD_OFFSET, 32'h0);
        apb(1'b1, `COUNT_VALUE_OFFSET, 32'h0);
        apb(1'b1, `CONTROL_WORD_OFFSET, {16'h0, c});
        if (o) osc_run <= 1'b1;
        else ext_run <= 1'b1;
        repeat (8 * b) @(posedge pclk);
        osc_run <= 1'b0;
        ext_run <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
    // reads the count with its setup 4 edges after the first pin edge: only
    // the synchronised path is still one tick behind there
    task latency(input logic [15:0] c, input logic [31:0] e);
        apb(1'b1, `CONTROL_WORD_OFFSET, 32'h0);
        apb(1'b1, `COUNT_VALUE_OFFSET, 32'h0);
        apb(1'b1, `CONTROL_WORD_OFFSET, {16'h0, c});
        ext_run <= 1'b1;
        repeat (7) @(posedge pclk);
        apb(1'b0, `COUNT_VALUE_OFFSET, 32'h0);
        check(q, e);
        ext_run <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, ext_run, osc_run, idle_mode} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(`CONTROL_WORD_OFFSET, 32'h0);
        rd(`COUNT_VALUE_OFFSET, 32'h0);
        rd(`PERIOD_OFFSET, 32'h0000FFFF);
        rd(`STATUS_OFFSET, 32'h0);
        rd(`MASK_OFFSET, 32'h0);
        rd(`SOURCE_OFFSET, 32'h0);
        rd(8'h18, 32'h0);
        apb(1'b1, `CONTROL_WORD_OFFSET, 32'hFFFF);
        rd(`CONTROL_WORD_OFFSET, 32'h0000A076);
        apb(1'b1, `CONTROL_WORD_OFFSET, 32'h0);
        for (k = 1; k < 4; k++) begin
            n = (k == 3) ? 256 : (1 << (3 * k));
            run(16'(16'h8000 | (k << 4)), 17 * n / 2 - 3, 32'h8);
        end
        idle_mode <= 1'b1;
        run(16'hA010, 65, 32'h0);
        run(16'h8010, 65, 32'h8);
        idle_mode <= 1'b0;
        apb(1'b1, `PERIOD_OFFSET, 32'h2);
        run(16'h8000, 1, 32'h1);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, `MASK_OFFSET, 32'h1);
        check({31'h0, irq}, 32'h1);
        rd(`STATUS_OFFSET, 32'h1);
        check({31'h0, irq}, 32'h0);
        rd(`STATUS_OFFSET, 32'h0);
        apb(1'b1, `MASK_OFFSET, 32'h0);
        apb(1'b1, `PERIOD_OFFSET, 32'hFFFF);
        burst(1'b0, 16'h8006, 5);
        rd(`COUNT_VALUE_OFFSET, 32'h5);
        apb(1'b1, `COUNT_VALUE_OFFSET, 32'h55);
        rd(`COUNT_VALUE_OFFSET, 32'h5);
        burst(1'b0, 16'h8002, 3);
        rd(`COUNT_VALUE_OFFSET, 32'h3);
        burst(1'b0, 16'h8040, 1);
        rd(`COUNT_VALUE_OFFSET, 32'h4);
        rd(`STATUS_OFFSET, 32'h2);
        latency(16'h8006, 32'h0);
        latency(16'h8002, 32'h1);
        apb(1'b1, `SOURCE_OFFSET, 32'h1);
        burst(1'b1, 16'h8002, 3);
        rd(`COUNT_VALUE_OFFSET, 32'h3);
        give_verdict;
    end
endmodule // rtc_capable_timer16_tb
bind rtc_capable_timer16 rtc_capable_timer16_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
